/* inc/dcf_pkg.sv */
// Constants shared by the control and format select block
package dcf_pkg;
  // Register offsets
  localparam logic [7:0] REG_CTRL0    = 8'h00;
  localparam logic [7:0] REG_CTRL1    = 8'h01;
  localparam logic [7:0] REG_CTRL2    = 8'h02;
  localparam logic [7:0] REG_DSDPATH  = 8'h06;
  localparam logic [7:0] REG_SYNC     = 8'h07;
  localparam logic [7:0] REG_DSDFILT  = 8'h09;
  localparam logic [7:0] REG_CHAIN    = 8'h0b;
  localparam logic [7:0] REG_AUTODET  = 8'h15;
  localparam logic [7:0] REG_STATUS   = 8'h20;
  // Field positions
  localparam int B_SOFT_RST_N = 0;
  localparam int B_AUTO_CLOCK_SETTING       = 1;
  localparam int B_FMT_LO     = 2;
  localparam int B_SOFT_MUTE_EN      = 0;
  localparam int B_DSD_SEL    = 0;
  localparam int B_DSD_RATIO  = 1;
  localparam int B_DSD_PATH   = 0;
  localparam int B_DSD_FSMUTE = 1;
  localparam int B_SYNC_EN    = 0;
  localparam int B_DSD_FILT   = 0;
  localparam int B_CHAIN      = 0;
  localparam int B_AUTODET    = 0;
  localparam int B_ST_OVERRUN = 5;
  // Reset values
  localparam logic [2:0] FMT_32B_MSB_RST = 3'h4;
  localparam logic       DSD_RATIO_512   = 1'b0;
  localparam logic       SYNC_EN_RST     = 1'b1;
  localparam logic       AUTODET_RST     = 1'b0;
  localparam logic       SOFT_RST_N_RST  = 1'b0;
  // Timing: one sample period and mode changeover
  localparam int MCLK_HZ          = 10000000;
  localparam int SAMPLE_PERIOD_NS = 20800;
  localparam int SAMPLE_CYC       = SAMPLE_PERIOD_NS / (1000000000 / MCLK_HZ);
  localparam int CHANGE_PERIODS   = 2;
  localparam int DSD_EDGE_LIMIT   = 4;
  // Control modes
  typedef enum logic [1:0] {
    CM_SERIAL3,
    CM_BUSREG,
    CM_PIN
  } dcf_ctrl_mode_e;
endpackage

/* design/dcf_top.sv */
// Control mode, conversion mode and pin routing for the converter input
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dcf_top
  import dcf_pkg::*;
(
  input  wire logic       mclk,            // System clock
  input  wire logic       reset,           // Synchronous reset
  input  wire logic [7:0] reg_addr,        // Register address
  input  wire logic [7:0] reg_wdata,       // Register write data
  input  wire logic       reg_wr,          // Write strobe
  input  wire logic       reg_rd,          // Read strobe
  output logic      [7:0] reg_rdata,       // Read data, cycle after strobe
  input  wire logic       power_down_n,    // Power-down pin
  input  wire logic       bus_select_strap,     // Register bus strap
  input  wire logic       control_select_strap, // Pin control strap
  input  wire logic [2:0] pin_format_sel,  // Format pins, pin mode
  input  wire logic       pin_soft_mute,   // Soft mute pin, pin mode
  input  wire logic [8:0] audio_pad_in,    // Shared audio pins 2..10
  output logic      [8:0] word_data,       // Captured word, bit 8 DSD
  output logic            word_valid,      // Word available
  input  wire logic       word_ready,      // Sink takes word
  output logic      [1:0] ctrl_mode,       // Active control mode
  output logic            dsd_mode,        // Active conversion mode
  output logic            mode_changing,   // Changeover in progress
  output logic      [2:0] pcm_format_sel,  // Effective PCM format
  output logic            auto_clock_setting,   // Effective clock mode
  output logic            soft_mute_en,    // Effective soft mute
  output logic            clock_sync_en,   // Effective clock sync
  output logic            daisy_chain_en,  // Effective daisy chain
  output logic            dsd_mclk_ratio,  // Effective DSD clock ratio
  output logic            dsd_filter_sel,  // Effective DSD filter
  output logic            dsd_path_sel,    // Effective DSD path
  output logic            dsd_fullscale_mute_en // Effective DSD mute
);

  localparam int SYNC_W = 16;
  localparam int CHG_CYC = CHANGE_PERIODS * SAMPLE_CYC;

  // Two-flop synchronisers for all pin inputs
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic [8:0]        pad_prev_q;
  always_ff @(posedge mclk) begin
    sync1_q <= {power_down_n, bus_select_strap, control_select_strap,
                pin_soft_mute, pin_format_sel, audio_pad_in};
    sync2_q <= sync1_q;
    pad_prev_q <= sync2_q[8:0];
  end

  wire       pdn_n_s  = sync2_q[15];
  wire       bsel_s   = sync2_q[14];
  wire       csel_s   = sync2_q[13];
  wire       psmute_s = sync2_q[12];
  wire [2:0] pfmt_s   = sync2_q[11:9];
  wire [8:0] pad_s    = sync2_q[8:0];
  wire [8:0] pad_rise = pad_s & ~pad_prev_q;
  wire       pad3_edge = pad_s[1] ^ pad_prev_q[1];
  wire       core_rst = reset | ~pdn_n_s;

  wire       bit_clock_rise = pad_rise[0];
  wire       frame_clock    = pad_s[1];
  wire [3:0] serial_data_in = pad_s[5:2];
  wire       dsd_clock_rise = pad_rise[0];
  wire [3:0] dsd_left_in  = {pad_s[7], pad_s[5], pad_s[3], pad_s[1]};
  wire [3:0] dsd_right_in = {pad_s[8], pad_s[6], pad_s[4], pad_s[2]};

  function automatic dcf_ctrl_mode_e strap_mode(input logic bsel,
                                                input logic csel);
    if (!bsel) begin
      strap_mode = CM_SERIAL3;
    end else if (!csel) begin
      strap_mode = CM_BUSREG;
    end else begin
      strap_mode = CM_PIN;
    end
  endfunction

  // straps follow pins only while powered down
  dcf_ctrl_mode_e cmode_q;
  always_ff @(posedge mclk) begin
    if (reset) begin
      cmode_q <= CM_SERIAL3;
    end else if (!pdn_n_s) begin
      cmode_q <= strap_mode(bsel_s, csel_s);
    end
  end
  wire pin_mode = (cmode_q == CM_PIN);

  // Register file
  logic       soft_rst_n_q;
  logic       auto_clock_setting_q;
  logic [2:0] fmt_q;
  logic       soft_mute_en_q;
  logic       dsd_sel_q;
  logic       dsd_ratio_q;
  logic       dsd_path_q;
  logic       dsd_fsmute_q;
  logic       sync_en_q;
  logic       dsd_filt_q;
  logic       chain_q;
  logic       autodet_q;
  logic       overrun_q;
  wire        overrun_set;
  wire        wr_ctrl0 = reg_wr & (reg_addr == REG_CTRL0);
  wire        wr_ctrl2 = reg_wr & (reg_addr == REG_CTRL2);
  wire        wr_stat  = reg_wr & (reg_addr == REG_STATUS);

  // Register writes; power-down restores reset values
  always_ff @(posedge mclk) begin
    if (core_rst) begin
      soft_rst_n_q <= SOFT_RST_N_RST;
      auto_clock_setting_q       <= 1'b0;
      fmt_q        <= FMT_32B_MSB_RST;
      soft_mute_en_q      <= 1'b0;
      dsd_sel_q    <= 1'b0;
      dsd_ratio_q  <= DSD_RATIO_512;
      dsd_path_q   <= 1'b0;
      dsd_fsmute_q <= 1'b0;
      sync_en_q    <= SYNC_EN_RST;
      dsd_filt_q   <= 1'b0;
      chain_q      <= 1'b0;
      autodet_q    <= AUTODET_RST;
    end else if (reg_wr) begin
      if (wr_ctrl0) begin
        soft_rst_n_q <= reg_wdata[B_SOFT_RST_N];
        auto_clock_setting_q       <= reg_wdata[B_AUTO_CLOCK_SETTING];
        fmt_q        <= reg_wdata[B_FMT_LO +: 3];
      end
      if (reg_addr == REG_CTRL1) soft_mute_en_q <= reg_wdata[B_SOFT_MUTE_EN];
      if (wr_ctrl2) begin
        dsd_sel_q   <= reg_wdata[B_DSD_SEL];
        dsd_ratio_q <= reg_wdata[B_DSD_RATIO];
      end
      if (reg_addr == REG_DSDPATH) begin
        dsd_path_q   <= reg_wdata[B_DSD_PATH];
        dsd_fsmute_q <= reg_wdata[B_DSD_FSMUTE];
      end
      if (reg_addr == REG_SYNC)    sync_en_q  <= reg_wdata[B_SYNC_EN];
      if (reg_addr == REG_DSDFILT) dsd_filt_q <= reg_wdata[B_DSD_FILT];
      if (reg_addr == REG_CHAIN)   chain_q    <= reg_wdata[B_CHAIN];
      if (reg_addr == REG_AUTODET) autodet_q  <= reg_wdata[B_AUTODET];
    end
  end

  // Sticky overrun; a new overrun beats the clear
  always_ff @(posedge mclk) begin
    if (core_rst) begin
      overrun_q <= 1'b0;
    end else begin
      overrun_q <= overrun_set |
                   (overrun_q & ~(wr_stat & reg_wdata[B_ST_OVERRUN]));
    end
  end

  // count pin 3 edges per sample period to spot DSD
  logic [15:0] win_cnt_q;
  logic [7:0]  edge_cnt_q;
  logic        auto_dsd_q;
  wire         win_end = (win_cnt_q == 16'(SAMPLE_CYC - 1));
  always_ff @(posedge mclk) begin
    if (core_rst) begin
      win_cnt_q  <= 16'h0000;
      edge_cnt_q <= 8'h00;
      auto_dsd_q <= 1'b0;
    end else if (win_end) begin
      win_cnt_q  <= 16'h0000;
      edge_cnt_q <= 8'h00;
      auto_dsd_q <= (edge_cnt_q > 8'(DSD_EDGE_LIMIT));
    end else begin
      win_cnt_q  <= win_cnt_q + 16'h0001;
      if (pad3_edge && edge_cnt_q != 8'hff) begin
        edge_cnt_q <= edge_cnt_q + 8'h01;
      end
    end
  end

  wire want_dsd = pin_mode ? 1'b0 :
                  (autodet_q ? auto_dsd_q : dsd_sel_q);
  // manual switch accepted only under soft reset
  wire switch_ok = pin_mode | autodet_q | ~soft_rst_n_q;

  // changeover timer of two sample periods
  logic        dsd_q;
  logic [15:0] chg_cnt_q;
  wire         chg_busy = (chg_cnt_q != 16'h0000);
  always_ff @(posedge mclk) begin
    if (core_rst) begin
      dsd_q     <= 1'b0;
      chg_cnt_q <= 16'h0000;
    end else if (chg_busy) begin
      chg_cnt_q <= chg_cnt_q - 16'h0001;
      if (chg_cnt_q == 16'h0001) dsd_q <= want_dsd;
    end else if (switch_ok && want_dsd != dsd_q) begin
      chg_cnt_q <= 16'(CHG_CYC);
    end
  end

  // PCM word on bit clock rise; DSD word on DSD clock rise
  wire       cap_edge = dsd_q ? dsd_clock_rise : bit_clock_rise;
  wire [8:0] cap_word = dsd_q ? {1'b1, dsd_left_in, dsd_right_in}
                              : {1'b0, 3'h0, frame_clock, serial_data_in};
  // no capture while soft reset or changeover holds the path
  // pin mode ignores the soft reset register
  wire       cap_req  = cap_edge & (pin_mode | soft_rst_n_q) & ~chg_busy;

  // Two-entry buffer: output stage plus skid stage
  logic [8:0] out_q;
  logic       out_v_q;
  logic [8:0] skid_q;
  logic       skid_v_q;
  wire        buf_ready = ~skid_v_q;
  wire        push = cap_req & buf_ready;
  wire        out_free = ~out_v_q | word_ready;
  assign overrun_set = cap_req & ~buf_ready;
  always_ff @(posedge mclk) begin
    if (core_rst) begin
      out_q    <= 9'h000;
      out_v_q  <= 1'b0;
      skid_q   <= 9'h000;
      skid_v_q <= 1'b0;
    end else if (out_free) begin
      out_v_q  <= skid_v_q | push;
      out_q    <= skid_v_q ? skid_q : cap_word;
      skid_v_q <= 1'b0;
    end else if (push) begin
      skid_q   <= cap_word;
      skid_v_q <= 1'b1;
    end
  end
  assign word_data  = out_q;
  assign word_valid = out_v_q;

  // pins in pin mode, registers otherwise; clock auto forced on in pin mode
  // register-only functions off in pin mode
  // settings gated by active conversion mode
  wire [2:0] eff_fmt   = pin_mode ? pfmt_s : fmt_q;
  wire       eff_auto_clock_setting  = pin_mode | auto_clock_setting_q;
  wire       eff_soft_mute_en = pin_mode ? psmute_s : soft_mute_en_q;
  wire       pcm_on    = ~dsd_q;
  wire       reg_on    = ~pin_mode;

  // Effective settings and status registered onto outputs
  always_ff @(posedge mclk) begin
    if (core_rst) begin
      ctrl_mode             <= 2'h0;
      dsd_mode              <= 1'b0;
      mode_changing         <= 1'b0;
      pcm_format_sel        <= 3'h0;
      auto_clock_setting    <= 1'b0;
      soft_mute_en          <= 1'b0;
      clock_sync_en         <= 1'b0;
      daisy_chain_en        <= 1'b0;
      dsd_mclk_ratio        <= 1'b0;
      dsd_filter_sel        <= 1'b0;
      dsd_path_sel          <= 1'b0;
      dsd_fullscale_mute_en <= 1'b0;
    end else begin
      ctrl_mode             <= cmode_q;
      dsd_mode              <= dsd_q;
      mode_changing         <= chg_busy;
      pcm_format_sel        <= pcm_on ? eff_fmt : 3'h0;
      auto_clock_setting    <= pcm_on & eff_auto_clock_setting;
      soft_mute_en          <= eff_soft_mute_en;
      clock_sync_en         <= pcm_on & reg_on & sync_en_q;
      daisy_chain_en        <= pcm_on & reg_on & chain_q;
      dsd_mclk_ratio        <= dsd_q & dsd_ratio_q;
      dsd_filter_sel        <= dsd_q & dsd_filt_q;
      dsd_path_sel          <= dsd_q & dsd_path_q;
      dsd_fullscale_mute_en <= dsd_q & dsd_fsmute_q;
    end
  end

  // Read mux, unmapped addresses read zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_addr)
      REG_CTRL0:   rd_mux = {3'h0, fmt_q, auto_clock_setting_q, soft_rst_n_q};
      REG_CTRL1:   rd_mux = {7'h00, soft_mute_en_q};
      REG_CTRL2:   rd_mux = {6'h00, dsd_ratio_q, dsd_sel_q};
      REG_DSDPATH: rd_mux = {6'h00, dsd_fsmute_q, dsd_path_q};
      REG_SYNC:    rd_mux = {7'h00, sync_en_q};
      REG_DSDFILT: rd_mux = {7'h00, dsd_filt_q};
      REG_CHAIN:   rd_mux = {7'h00, chain_q};
      REG_AUTODET: rd_mux = {7'h00, autodet_q};
      REG_STATUS:  rd_mux = {2'h0, overrun_q, chg_busy, dsd_q, 1'b0,
                             cmode_q};
      default:     rd_mux = 8'h00;
    endcase
  end

  // Read data stands one cycle after the strobe
  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

endmodule // dcf_top
`default_nettype wire

/* bench/dcf_top_sva.sv */
// Assertions on the control and format select outputs
`timescale 1ns/1ps
`default_nettype none
module dcf_top_chk
  import dcf_pkg::*;
(
  input wire logic       mclk,               // Clock
  input wire logic       reset,              // Reset
  input wire logic       reg_rd,             // Read strobe
  input wire logic [7:0] reg_rdata,          // Read data
  input wire logic [8:0] word_data,          // Word
  input wire logic       word_valid,         // Word held
  input wire logic       word_ready,         // Sink ready
  input wire logic [1:0] ctrl_mode,          // Control mode
  input wire logic       dsd_mode,           // DSD active
  input wire logic       mode_changing,      // Changeover
  input wire logic [2:0] pcm_format_sel,     // PCM format
  input wire logic       auto_clock_setting, // Clock auto
  input wire logic       clock_sync_en,      // Sync
  input wire logic       daisy_chain_en,     // Chain
  input wire logic       dsd_mclk_ratio,     // Ratio
  input wire logic       dsd_filter_sel,     // Filter
  input wire logic       dsd_path_sel,       // Path
  input wire logic       dsd_fullscale_mute_en // Full-scale mute
);
  logic [9:0] chg_q; // Cycles spent changing
  logic [9:0] chg_d;
  // Changeover length counter
  assign chg_d = mode_changing ? chg_q + 10'h001 : 10'h000;
  always_ff @(posedge mclk) chg_q <= reset ? 10'h000 : chg_d;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  property p_mode_legal; ctrl_mode != 2'h3; endproperty
  property p_pin_pcm;
    ctrl_mode == 2'h2 |-> !dsd_mode && auto_clock_setting;
  endproperty
  property p_pin_regonly;
    ctrl_mode == 2'h2 |-> {clock_sync_en, daisy_chain_en, dsd_filter_sel,
      dsd_path_sel, dsd_fullscale_mute_en} == 5'h00;
  endproperty
  property p_dsd_nopcm; dsd_mode |-> {pcm_format_sel, auto_clock_setting,
    clock_sync_en, daisy_chain_en} == 6'h00;
  endproperty
  property p_pcm_nodsd; !dsd_mode |-> {dsd_mclk_ratio, dsd_filter_sel,
    dsd_path_sel, dsd_fullscale_mute_en} == 4'h0;
  endproperty
  property p_dsd_after; $rose(dsd_mode) |-> $past(mode_changing); endproperty
  property p_chg_min; $fell(mode_changing) |-> chg_q >= 2*SAMPLE_CYC-2;
  endproperty
  property p_chg_max; mode_changing |-> chg_q < 3*SAMPLE_CYC; endproperty
  property p_rd_only; reg_rdata != 8'h00 |-> $past(reg_rd); endproperty
  property p_word_hold;
    word_valid && !word_ready |=> word_valid && $stable(word_data);
  endproperty
  a_mode_legal: assert property (p_mode_legal)
    else $error("control mode code out of range");
  a_pin_pcm: assert property (p_pin_pcm)
    else $error("pin mode left PCM or clock auto");
  a_pin_regonly: assert property (p_pin_regonly)
    else $error("register-only setting active in pin mode");
  a_dsd_nopcm: assert property (p_dsd_nopcm)
    else $error("PCM setting active in DSD");
  a_pcm_nodsd: assert property (p_pcm_nodsd)
    else $error("DSD setting active in PCM");
  a_dsd_after: assert property (p_dsd_after)
    else $error("DSD entered without changeover");
  a_chg_min: assert property (p_chg_min)
    else $error("changeover too short");
  a_chg_max: assert property (p_chg_max)
    else $error("changeover too long");
  a_rd_only: assert property (p_rd_only)
    else $error("read data outside read slot");
  a_word_hold: assert property (p_word_hold)
    else $error("word lost or changed while stalled");
  c_dsd: cover property ($rose(dsd_mode));
  c_take: cover property (word_valid && word_ready);
  c_pin: cover property (ctrl_mode == 2'h2);
endmodule // dcf_top_chk
bind dcf_top dcf_top_chk u_chk (
  .mclk                  (mclk),
  .reset                 (reset),
  .reg_rd                (reg_rd),
  .reg_rdata             (reg_rdata),
  .word_data             (word_data),
  .word_valid            (word_valid),
  .word_ready            (word_ready),
  .ctrl_mode             (ctrl_mode),
  .dsd_mode              (dsd_mode),
  .mode_changing         (mode_changing),
  .pcm_format_sel        (pcm_format_sel),
  .auto_clock_setting    (auto_clock_setting),
  .clock_sync_en         (clock_sync_en),
  .daisy_chain_en        (daisy_chain_en),
  .dsd_mclk_ratio        (dsd_mclk_ratio),
  .dsd_filter_sel        (dsd_filter_sel),
  .dsd_path_sel          (dsd_path_sel),
  .dsd_fullscale_mute_en (dsd_fullscale_mute_en)
);
`default_nettype wire

/* bench/dcf_audio_src.sv */
// Audio source model driving the shared input pads
`timescale 1ns/1ps
`default_nettype none
module dcf_audio_src (
  input  wire logic       run,  // Send bits while high
  output logic      [8:0] pads  // Pads 2..10
);
  // 800 ns link clock, low between frames, data moves on fall
  initial begin
    pads = 9'h000;
    #137;
    forever begin
      #400;
      if (pads[0]) begin
        pads[0] = 1'b0;
        if (run) pads[8:1] = 8'($urandom);
      end else if (run) begin
        pads[0] = 1'b1;
      end
    end
  end
endmodule // dcf_audio_src
`default_nettype wire

/* bench/tb_dac_control_and_format_select.sv */
// Testbench for the control and format select block
`timescale 1ns/1ps
`default_nettype none
module tb_dac_control_and_format_select;
  import dcf_pkg::*;
  logic mclk, reset, reg_wr, reg_rd, power_down_n, word_ready, word_valid;
  logic bus_select_strap, control_select_strap, pin_soft_mute, soft_mute_en;
  logic src_run, stall, mon_on, exp_dsd, dsd_mode, mode_changing;
  logic auto_clock_setting, clock_sync_en, daisy_chain_en, dsd_mclk_ratio;
  logic dsd_filter_sel, dsd_path_sel, dsd_fullscale_mute_en;
  logic [1:0] ctrl_mode;
  logic [2:0] pin_format_sel, pcm_format_sel;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_q;
  logic [8:0] audio_pad_in, word_data;
  logic [8:0] exp_q[$];
  wire  [2:0] pcm_set = {auto_clock_setting, clock_sync_en, daisy_chain_en};
  wire  [3:0] dsd_set = {dsd_mclk_ratio, dsd_filter_sel, dsd_path_sel,
                         dsd_fullscale_mute_en};
  logic [15:0] rst_tab[6] = '{16'h0010, 16'h0100, 16'h0200, 16'h0701,
                              16'h1500, 16'h3000};
  int num_errors = 0;
  int tests_run = 0;
  int i;
  dcf_top dut (
    .mclk                  (mclk),
    .reset                 (reset),
    .reg_addr              (reg_addr),
    .reg_wdata             (reg_wdata),
    .reg_wr                (reg_wr),
    .reg_rd                (reg_rd),
    .reg_rdata             (reg_rdata),
    .power_down_n          (power_down_n),
    .bus_select_strap      (bus_select_strap),
    .control_select_strap  (control_select_strap),
    .pin_format_sel        (pin_format_sel),
    .pin_soft_mute         (pin_soft_mute),
    .audio_pad_in          (audio_pad_in),
    .word_data             (word_data),
    .word_valid            (word_valid),
    .word_ready            (word_ready),
    .ctrl_mode             (ctrl_mode),
    .dsd_mode              (dsd_mode),
    .mode_changing         (mode_changing),
    .pcm_format_sel        (pcm_format_sel),
    .auto_clock_setting    (auto_clock_setting),
    .soft_mute_en          (soft_mute_en),
    .clock_sync_en         (clock_sync_en),
    .daisy_chain_en        (daisy_chain_en),
    .dsd_mclk_ratio        (dsd_mclk_ratio),
    .dsd_filter_sel        (dsd_filter_sel),
    .dsd_path_sel          (dsd_path_sel),
    .dsd_fullscale_mute_en (dsd_fullscale_mute_en)
  );
  dcf_audio_src src (.run(src_run), .pads(audio_pad_in));
  // Clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Expected word from the pads at a link clock rise
  function automatic logic [8:0] exp_word(input logic d, input logic [8:0] p);
    return d ? {1'b1, p[7], p[5], p[3], p[1], p[8], p[6], p[4], p[2]}
             : {4'h0, p[1], p[5], p[4], p[3], p[2]};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    rd_q = reg_rdata;
  endtask
  task automatic straps(input logic b, input logic c);
    @(posedge mclk);
    power_down_n <= 1'b0;
    repeat (2) @(posedge mclk);
    bus_select_strap <= b;
    control_select_strap <= c;
    repeat (6) @(posedge mclk);
    power_down_n <= 1'b1;
    repeat (6) @(posedge mclk);
  endtask
  task automatic send(input int n);
    src_run = 1'b1;
    repeat (n) @(posedge audio_pad_in[0]);
    src_run = 1'b0;
    repeat (30) @(posedge mclk);
  endtask
  task automatic wait_mode(input logic m, input int lim);
    for (i = 0; i < lim && dsd_mode !== m; i++) @(posedge mclk);
  endtask
  task automatic finish_test;
    $display("Checks %0d, errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Expected words recorded at each link clock rise
  always @(posedge audio_pad_in[0])
    if (mon_on) exp_q.push_back(exp_word(exp_dsd, audio_pad_in));
  // Sink with random stalls compares every word taken
  always @(posedge mclk) begin
    if (word_valid === 1'b1 && word_ready === 1'b1)
      chk(word_data, exp_q.pop_front());
    word_ready <= !stall && ($urandom % 4 != 0);
  end
  // Watchdog
  initial begin
    repeat (30000) @(posedge mclk);
    num_errors++;
    finish_test();
  end
  initial begin
    {reg_wr, reg_rd, word_ready, stall, mon_on, exp_dsd, src_run} = 7'h00;
    {reg_addr, reg_wdata} = 16'h0000;
    {power_down_n, bus_select_strap, control_select_strap} = 3'b010;
    pin_soft_mute = 1'b1;
    i = $urandom(45);
    pin_format_sel = 3'($urandom % 7);
    reset = 1'b1;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      straps(k[1], k[0]);
      rd(REG_STATUS);
      chk(9'(rd_q[1:0]), 9'(k == 3 ? 2 : k >> 1));
      chk(9'(ctrl_mode), 9'(k == 3 ? 2 : k >> 1));
    end
    // Pin mode: register writes must have no effect
    wr(REG_CTRL0, 8'h1c);
    wr(REG_CTRL2, 8'h01);
    wr(REG_CHAIN, 8'h01);
    mon_on = 1'b1;
    send(4);
    mon_on = 1'b0;
    repeat (600) @(posedge mclk);
    chk(9'(pcm_format_sel), 9'(pin_format_sel));
    chk(9'(pcm_set), 9'h004);
    chk(9'(soft_mute_en), 9'(pin_soft_mute));
    chk(9'(dsd_mode), 9'h000);
    straps(1'b1, 1'b0);
    foreach (rst_tab[j]) begin
      rd(rst_tab[j][15:8]);
      chk(9'(rd_q), 9'(rst_tab[j][7:0]));
    end
    chk(9'(pcm_format_sel), 9'(FMT_32B_MSB_RST));
    chk(9'(soft_mute_en), 9'h000);
    wr(REG_CTRL1, 8'h01);
    wr(REG_CTRL0, 8'h13);
    wr(REG_CHAIN, 8'h01);
    repeat (2) @(posedge mclk);
    chk(9'(soft_mute_en), 9'h001);
    chk(9'(pcm_set), 9'h007);
    mon_on = 1'b1;
    send(20);
    // Fill the buffer until it refuses, then drain
    stall = 1'b1;
    send(3);
    rd(REG_STATUS);
    chk(9'(rd_q[5]), 9'h001);
    void'(exp_q.pop_back());
    wr(REG_STATUS, 8'h20);
    rd(REG_STATUS);
    chk(9'(rd_q[5]), 9'h000);
    stall = 1'b0;
    repeat (30) @(posedge mclk);
    chk(9'(exp_q.size()), 9'h000);
    // manual switch to DSD under soft reset
    wr(REG_CTRL0, 8'h10);
    wr(REG_CTRL2, 8'h01);
    repeat (3) @(posedge mclk);
    chk(9'(mode_changing), 9'h001);
    wait_mode(1'b1, 700);
    chk(9'(dsd_mode), 9'h001);
    // soft reset and data held back four sample periods
    repeat (4 * SAMPLE_CYC) @(posedge mclk);
    wr(REG_CTRL2, 8'h03);
    wr(REG_DSDPATH, 8'h03);
    wr(REG_DSDFILT, 8'h01);
    wr(REG_CTRL0, 8'h13);
    exp_dsd = 1'b1;
    send(12);
    chk(9'(dsd_set), 9'h00f);
    chk(9'(pcm_set), 9'h000);
    chk(9'(pcm_format_sel), 9'h000);
    chk(9'(exp_q.size()), 9'h000);
    wr(REG_CTRL2, 8'h02);
    repeat (700) @(posedge mclk);
    chk(9'(dsd_mode), 9'h001);
    wr(REG_CTRL0, 8'h10);
    wait_mode(1'b0, 700);
    chk(9'(dsd_mode), 9'h000);
    chk(9'(dsd_set), 9'h000);
    // Automatic selection follows frame pin activity only
    mon_on = 1'b0;
    wr(REG_AUTODET, 8'h01);
    src_run = 1'b1;
    wait_mode(1'b1, 1500);
    src_run = 1'b0;
    chk(9'(dsd_mode), 9'h001);
    wait_mode(1'b0, 1500);
    chk(9'(dsd_mode), 9'h000);
    finish_test();
  end
endmodule // tb_dac_control_and_format_select
`default_nettype wire
